// [rtl/ddrsp_ctrl.sv]
// Purpose: holds one command from software until every spacing allows it
// Assumes: two bank groups of four banks, one device clock domain
// Notes: software polls status bit 16 before writing the next command
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ddrsp_ctrl
  import ddrsp_pkg::*;
(
  input  wire logic          clock_in,     // 20 MHz
  input  wire logic          reset_in,     // sync, high
  input  wire logic [7:0]    addr_in,      // byte address
  input  wire logic [31:0]   wdata_in,     // write data
  input  wire logic          wr_in,        // write strobe
  input  wire logic          rd_in,        // read strobe
  output logic      [31:0]   rdata_out,    // read data, next cycle
  output ddrsp_cmd_type      cmd_out,      // command fields
  output logic               cmd_valid_out,// command cycle
  output logic               cs_n_out,     // chip select, low active
  input  wire logic          dq0_in,       // data bit 0 pin level
  output logic               dq0_out,      // data bit 0 drive value
  output logic               dq0_oe_out    // data bit 0 drive enable
);
  // count down to zero and stay
  function automatic logic [7:0] dec(input logic [7:0] x);
    return (x == 8'h00) ? 8'h00 : x - 8'h01;
  endfunction : dec

  ddrsp_ctrl_type  ctrl_ff;          // control word
  ddrsp_cmd_type   pend_ff;          // held command
  logic            pend_v_ff;        // command waiting
  ddrsp_state_type state_ff;         // sequencer state
  ddrsp_state_type nxt_state;        // next state
  logic [7:0]      lead_ff;          // lead cycles left
  logic [7:0]      pda_ff;           // dq0 hold cycles left
  logic [15:0]     issued_ff;        // issued command count
  logic [31:0]     rdata_ff;         // read data register
  logic            dq0_s1_ff;        // dq0 sync stage 1
  logic            dq0_s2_ff;        // dq0 sync stage 2
  logic [7:0]      col_bg_ff [2];    // column gap per group
  logic [7:0]      col_any_ff;       // column gap any group
  logic [7:0]      act_bg_ff [2];    // activate gap per group
  logic [7:0]      act_any_ff;       // activate gap any group
  logic [7:0]      faw_ff [4];       // window cycles left per last four activates
  logic [1:0]      faw_ptr_ff;       // oldest activate slot
  logic [7:0]      wtr_bg_ff [2];    // write-read gap per group
  logic [7:0]      wtr_any_ff;       // write-read gap any group
  logic [7:0]      rtp_ff [8];       // read to precharge per bank
  logic [7:0]      wrr_ff [8];       // write recovery per bank
  logic [7:0]      busy_ff [8];      // bank closing per bank
  logic [7:0]      mrd_ff;           // mode set to mode set
  logic [7:0]      mod_ff;           // mode set update delay
  logic [7:0]      mpr_ff;           // mpr recovery
  logic            ok;               // held command may go
  logic            iss;              // command cycle
  logic [2:0]      bidx;             // flat bank index
  logic [7:0]      crcx;             // crc plus mask extension
  logic            is_col;           // read or write kind
  logic            is_rd;            // any read kind

  assign iss    = (state_ff == S_ISSUE);
  assign bidx   = {pend_ff.bg, pend_ff.bank};
  assign is_rd  = (pend_ff.kind == K_RD) || (pend_ff.kind == K_MPR_RD);
  assign is_col = is_rd || (pend_ff.kind == K_WR) || (pend_ff.kind == K_MPR_WR);
  // extension only with crc and mask both on
  assign crcx   = (ctrl_ff.crc_en && ctrl_ff.data_mask) ? CRCDM_CYC : 8'h00;  // RL9

  // control and command registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_ff   <= CTRL_RST;
      pend_ff   <= '0;
      pend_v_ff <= 1'b0;
    end else begin
      if (wr_in && addr_in == REG_CTRL) begin
        ctrl_ff <= ddrsp_ctrl_type'(wdata_in[CTRL_W-1:0]);
      end
      if (iss) begin
        pend_v_ff <= 1'b0;  // taken by the device
      end else if (wr_in && addr_in == REG_CMD && !pend_v_ff) begin
        pend_ff   <= ddrsp_cmd_type'(wdata_in[CMD_W-1:0]);
        pend_v_ff <= 1'b1;  // a write while busy is ignored
      end
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_in) begin
      if (addr_in == REG_CTRL) begin
        rdata_ff <= {11'h000, ctrl_ff};
      end else if (addr_in == REG_CMD) begin
        rdata_ff <= {25'h0000000, pend_ff};
      end else if (addr_in == REG_STAT) begin
        rdata_ff <= {12'h000, dq0_s2_ff, state_ff, pend_v_ff, issued_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;  // unmapped
      end
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end
  assign rdata_out = rdata_ff;

  // dq0 pin synchroniser
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      dq0_s1_ff <= 1'b0;
      dq0_s2_ff <= 1'b0;
    end else begin
      dq0_s1_ff <= dq0_in;
      dq0_s2_ff <= dq0_s1_ff;
    end
  end

  // may the held command go now
  always_comb begin
    ok = 1'b0;
    case (pend_ff.kind)
      K_ACT: begin
        ok = busy_ff[bidx] == 8'h00                            // RL16
          && act_bg_ff[pend_ff.bg] == 8'h00                    // RL4
          && act_any_ff == 8'h00                               // RL3
          && faw_ff[faw_ptr_ff] == 8'h00;                      // RL5
      end
      K_RD, K_WR: begin
        ok = col_bg_ff[pend_ff.bg] == 8'h00                    // RL1
          && col_any_ff == 8'h00                               // RL2
          && (!is_rd || wtr_bg_ff[pend_ff.bg] == 8'h00)        // RL7
          && (!is_rd || wtr_any_ff == 8'h00);                  // RL6
      end
      K_PRE: begin
        ok = rtp_ff[bidx] == 8'h00                             // RL8
          && wrr_ff[bidx] == 8'h00;                            // RL9
      end
      K_MRS: begin
        ok = mrd_ff == 8'h00 && mpr_ff == 8'h00;               // RL12
      end
      K_MPR_RD, K_MPR_WR: begin
        ok = col_any_ff == 8'h00 && mpr_ff == 8'h00;           // RL14
      end
      default: begin
        ok = 1'b1;
      end
    endcase
    // nothing but mode sets before the update delay ends
    if (pend_ff.kind != K_MRS && (mod_ff != 8'h00 || mpr_ff != 8'h00)) begin
      ok = 1'b0;  // RL13
    end
  end

  // sequencer: idle, chip select lead, command cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (pend_v_ff && ok) begin
          if (ctrl_ff.cal_en || (ctrl_ff.per_device_addressing && pend_ff.kind == K_MRS)) begin
            nxt_state = S_LEAD;
          end else begin
            nxt_state = S_ISSUE;
          end
        end
      end
      S_LEAD: begin
        if (lead_ff <= 8'h01) begin
          nxt_state = S_ISSUE;
        end
      end
      S_ISSUE: begin
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  // state, lead count, issue count
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff  <= S_IDLE;
      lead_ff   <= 8'h00;
      issued_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == S_IDLE && nxt_state == S_LEAD) begin
        lead_ff <= ctrl_ff.cal_en ? CAL_CYC : 8'h01;  // RL18
      end else begin
        lead_ff <= dec(lead_ff);
      end
      if (iss) begin
        issued_ff <= issued_ff + 16'h0001;
      end
    end
  end

  // pin drive: chip select leads in latency mode
  assign cmd_out       = pend_ff;
  assign cmd_valid_out = iss;
  assign cs_n_out      = !(iss || (state_ff == S_LEAD && ctrl_ff.cal_en));  // RL18

  // dq0 held low around a per device mode set
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pda_ff <= 8'h00;
    end else if (iss && ctrl_ff.per_device_addressing && pend_ff.kind == K_MRS) begin
      pda_ff <= PDA_HOLD_CYC;  // RL17
    end else begin
      pda_ff <= dec(pda_ff);
    end
  end
  assign dq0_out    = 1'b0;
  assign dq0_oe_out = (pda_ff != 8'h00)
                   || (ctrl_ff.per_device_addressing && pend_ff.kind == K_MRS
                       && (state_ff == S_LEAD || iss));  // RL17

  // per group column, activate and write-read counters
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bg
      always_ff @(posedge clock_in) begin
        if (reset_in) begin
          col_bg_ff[g] <= 8'h00;
          act_bg_ff[g] <= 8'h00;
          wtr_bg_ff[g] <= 8'h00;
        end else begin
          if (iss && is_col && pend_ff.bg == 1'(g)) begin
            col_bg_ff[g] <= CCD_L_CYC;  // RL1 RL21
          end else begin
            col_bg_ff[g] <= dec(col_bg_ff[g]);
          end
          if (iss && pend_ff.kind == K_ACT && pend_ff.bg == 1'(g)) begin
            act_bg_ff[g] <= RRD_L_CYC;  // RL4 RL21
          end else begin
            act_bg_ff[g] <= dec(act_bg_ff[g]);
          end
          if (iss && pend_ff.kind == K_WR && pend_ff.bg == 1'(g)) begin
            wtr_bg_ff[g] <= WTR_L_CYC + crcx;  // RL7 RL11
          end else begin
            wtr_bg_ff[g] <= dec(wtr_bg_ff[g]);
          end
        end
      end
    end
  endgenerate

  // any group counters and activate window
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      col_any_ff <= 8'h00;
      act_any_ff <= 8'h00;
      wtr_any_ff <= 8'h00;
      faw_ptr_ff <= 2'b00;
      for (int k = 0; k < 4; k++) begin
        faw_ff[k] <= 8'h00;
      end
    end else begin
      col_any_ff <= (iss && is_col) ? CCD_S_CYC : dec(col_any_ff);  // RL2
      act_any_ff <= (iss && pend_ff.kind == K_ACT) ? RRD_S_CYC : dec(act_any_ff);  // RL3
      wtr_any_ff <= (iss && pend_ff.kind == K_WR) ? WTR_S_CYC + crcx : dec(wtr_any_ff);  // RL6 RL10
      for (int k = 0; k < 4; k++) begin
        if (iss && pend_ff.kind == K_ACT && faw_ptr_ff == 2'(k)) begin
          faw_ff[k] <= FAW_CYC;  // RL5
        end else begin
          faw_ff[k] <= dec(faw_ff[k]);
        end
      end
      if (iss && pend_ff.kind == K_ACT) begin
        faw_ptr_ff <= faw_ptr_ff + 2'b01;
      end
    end
  end

  // per bank precharge and recovery counters
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bank
      logic hit;  // command names this bank
      assign hit = iss && bidx == 3'(b);
      always_ff @(posedge clock_in) begin
        if (reset_in) begin
          rtp_ff[b]  <= 8'h00;
          wrr_ff[b]  <= 8'h00;
          busy_ff[b] <= 8'h00;
        end else begin
          rtp_ff[b] <= (hit && pend_ff.kind == K_RD) ? RTP_CYC : dec(rtp_ff[b]);  // RL8 RL21
          wrr_ff[b] <= (hit && pend_ff.kind == K_WR) ? WR_CYC + crcx : dec(wrr_ff[b]);  // RL9
          if (hit && pend_ff.kind == K_WR && pend_ff.ap) begin
            busy_ff[b] <= ctrl_ff.wr_prog + RP_CYC;  // RL16
          end else if (hit && pend_ff.kind == K_RD && pend_ff.ap) begin
            busy_ff[b] <= RTP_CYC + RP_CYC;
          end else if (hit && pend_ff.kind == K_PRE) begin
            busy_ff[b] <= RP_CYC;
          end else begin
            busy_ff[b] <= dec(busy_ff[b]);
          end
        end
      end
    end
  endgenerate

  // mode register and mpr timing
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mrd_ff <= 8'h00;
      mod_ff <= 8'h00;
      mpr_ff <= 8'h00;
    end else begin
      if (iss && pend_ff.kind == K_MRS) begin
        mrd_ff <= ctrl_ff.cal_en ? MOD_CYC + CAL_CYC : MRD_CYC;  // RL12 RL19
        mod_ff <= ctrl_ff.cal_en ? MOD_CYC + CAL_CYC : MOD_CYC;  // RL13 RL19
      end else begin
        mrd_ff <= dec(mrd_ff);
        mod_ff <= dec(mod_ff);
      end
      if (iss && pend_ff.kind == K_MPR_WR) begin
        mpr_ff <= MOD_CYC + {3'b000, ctrl_ff.additive_latency}
                + {4'h0, ctrl_ff.parity_latency};  // RL15
      end else if (iss && pend_ff.kind == K_MPR_RD) begin
        mpr_ff <= MPRR_CYC;  // RL14
      end else begin
        mpr_ff <= dec(mpr_ff);
      end
    end
  end
endmodule : ddrsp_ctrl

// [rtl/ddrsp_pkg.sv]
// Purpose: constants and types for the ddr4 command spacing controller
// Assumes: one 20 MHz clock; every device spacing is counted in these cycles
// Notes: ns minimums are held in ps and turned into cycles below
// How it works
// RL1 - same group column commands: max(5nCK,5ns)
// RL2 - other group column commands: four cycles
// RL3 - activates, other group: max(4nCK,5.3ns)
// RL4 - activates, same group: max(4nCK,6.4ns)
// RL5 - at most four activates per window
// RL6 - write to read, other group: max(2nCK,2.5ns)
// RL7 - write to read, same group: max(4nCK,7.5ns)
// RL8 - read to precharge gap: max(4nCK,7.5ns)
// RL9 - write recovery 15ns, longer with crc+mask
// RL10 - other group write-read grows with crc+mask
// RL11 - same group write-read grows with crc+mask
// RL12 - mode register sets eight cycles apart
// RL13 - wait update delay after mode set
// RL14 - one cycle after multi-purpose register access
// RL15 - mpr write waits update+additive+parity latency
// RL16 - auto precharge write recovery plus precharge
// RL17 - per device addressing holds data bit0 low
// RL18 - chip select leads command in latency mode
// RL19 - latency mode adds it to mode spacing
// RL20 - ns minimums round up, take larger
// RL21 - separate counters per group and bank
package ddrsp_pkg;
  localparam int CLK_PS = 50000;  // clock period in ps

  // ns to cycles rounded up, never under one, then max with nCK
  function automatic int cyc(input int nck, input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;  // RL20
    if (c < 1) c = 1;
    return (nck > c) ? nck : c;  // RL20
  endfunction : cyc

  localparam int CCD_L_NCK = 5;     localparam int CCD_L_PS = 5000;
  localparam int CCD_S_NCK = 4;
  localparam int RRD_S_NCK = 4;     localparam int RRD_S_PS = 5300;
  localparam int RRD_L_NCK = 4;     localparam int RRD_L_PS = 6400;
  localparam int FAW_NCK   = 28;    localparam int FAW_PS   = 30000;
  localparam int WTR_S_NCK = 2;     localparam int WTR_S_PS = 2500;
  localparam int WTR_L_NCK = 4;     localparam int WTR_L_PS = 7500;
  localparam int RTP_NCK   = 4;     localparam int RTP_PS   = 7500;
  localparam int WR_PS     = 15000;
  localparam int CRCDM_NCK = 5;     localparam int CRCDM_PS = 3750;
  localparam int MRD_NCK   = 8;
  localparam int MOD_NCK   = 24;    localparam int MOD_PS   = 15000;
  localparam int MPRR_NCK  = 1;
  localparam int CAL_NCK   = 3;     localparam int CAL_PS   = 3748;
  localparam int RP_PS     = 13750; // precharge time, plain default

  localparam logic [7:0] CCD_L_CYC = 8'(cyc(CCD_L_NCK, CCD_L_PS));
  localparam logic [7:0] CCD_S_CYC = 8'(CCD_S_NCK);
  localparam logic [7:0] RRD_S_CYC = 8'(cyc(RRD_S_NCK, RRD_S_PS));
  localparam logic [7:0] RRD_L_CYC = 8'(cyc(RRD_L_NCK, RRD_L_PS));
  localparam logic [7:0] FAW_CYC   = 8'(cyc(FAW_NCK, FAW_PS));
  localparam logic [7:0] WTR_S_CYC = 8'(cyc(WTR_S_NCK, WTR_S_PS));
  localparam logic [7:0] WTR_L_CYC = 8'(cyc(WTR_L_NCK, WTR_L_PS));
  localparam logic [7:0] RTP_CYC   = 8'(cyc(RTP_NCK, RTP_PS));
  localparam logic [7:0] WR_CYC    = 8'(cyc(1, WR_PS));
  localparam logic [7:0] CRCDM_CYC = 8'(cyc(CRCDM_NCK, CRCDM_PS));
  localparam logic [7:0] MRD_CYC   = 8'(MRD_NCK);
  localparam logic [7:0] MOD_CYC   = 8'(cyc(MOD_NCK, MOD_PS));
  localparam logic [7:0] MPRR_CYC  = 8'(MPRR_NCK);
  localparam logic [7:0] CAL_CYC   = 8'(cyc(CAL_NCK, CAL_PS));
  localparam logic [7:0] RP_CYC    = 8'(cyc(1, RP_PS));
  localparam logic [7:0] PDA_HOLD_CYC = 8'h01;  // dq0 low after command

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD  = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CTRL_W = 21;  // ctrl occupies wdata[20:0]
  localparam int CMD_W  = 7;   // command occupies wdata[6:0]

  // command kinds
  typedef enum logic [2:0] {
    K_NOP = 3'b000, K_ACT = 3'b001, K_RD = 3'b010, K_WR = 3'b011,
    K_PRE = 3'b100, K_MRS = 3'b101, K_MPR_RD = 3'b110, K_MPR_WR = 3'b111
  } ddrsp_kind_type;

  // command toward the device pins
  typedef struct packed {
    ddrsp_kind_type kind;  // [6:4]
    logic           bg;    // [3] bank group
    logic [1:0]     bank;  // [2:1]
    logic           ap;    // [0] auto precharge
  } ddrsp_cmd_type;

  // control word
  typedef struct packed {
    logic [7:0] wr_prog;  // [20:13] programmed write recovery, cycles
    logic [3:0] parity_latency;    // [12:9]
    logic [4:0] additive_latency;  // [8:4]
    logic       per_device_addressing;  // [3]
    logic       cal_en;   // [2] chip select latency mode
    logic       data_mask;  // [1]
    logic       crc_en;   // [0]
  } ddrsp_ctrl_type;

  localparam ddrsp_ctrl_type CTRL_RST = '{wr_prog: WR_CYC, default: '0};

  // issue sequencer
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_LEAD = 2'b01, S_ISSUE = 2'b10
  } ddrsp_state_type;
endpackage : ddrsp_pkg

// [dv/ddrsp_properties.sv]
// Purpose: spacing checks on the command pins of the controller
// Assumes: 50 ns clock, so every ns minimum folds to one cycle
// Notes: gaps are counted between command pulses
`timescale 1ns/1ps
module ddrsp_properties
  import ddrsp_pkg::*;
(
  input wire logic          clock_in,
  input wire logic          reset_in,
  input wire logic [7:0]    addr_in,
  input wire logic [31:0]   wdata_in,
  input wire logic          wr_in,
  input wire ddrsp_cmd_type cmd_out,
  input wire logic          cmd_valid_out,
  input wire logic          cs_n_out,
  input wire logic          dq0_out,
  input wire logic          dq0_oe_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  ddrsp_ctrl_type ctrl_ff;     // mirror of control word
  int             cyc_ff;      // free cycle count
  int             t_col_ff;    // last column command
  int             t_wr_ff;     // last write
  int             t_rd_ff;     // last read
  int             t_mrs_ff;    // last mode set
  int             t_act_ff[4]; // last four activates, newest first
  logic           col_bg_ff;   // group of last column
  logic           wr_bg_ff;    // group of last write
  logic [2:0]     rd_bk_ff;    // bank of last read
  wire logic v = cmd_valid_out;
  wire logic col = v && (cmd_out.kind == K_RD || cmd_out.kind == K_WR);
  wire logic act = v && cmd_out.kind == K_ACT;
  wire logic mrs = v && cmd_out.kind == K_MRS;
  wire logic crcdm = ctrl_ff.crc_en && ctrl_ff.data_mask;
  // stamp column, write, read, mode set and activate commands as they leave
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_ff <= CTRL_RST;
      cyc_ff <= 1000;
      t_col_ff <= 0;
      t_wr_ff <= 0;
      t_rd_ff <= 0;
      t_mrs_ff <= 0;
      t_act_ff <= '{default: 0};
    end else begin
      cyc_ff <= cyc_ff + 1;
      if (wr_in && addr_in == REG_CTRL) ctrl_ff <= ddrsp_ctrl_type'(wdata_in[CTRL_W-1:0]);
      if (col) begin t_col_ff <= cyc_ff; col_bg_ff <= cmd_out.bg; end
      if (v && cmd_out.kind == K_WR) begin t_wr_ff <= cyc_ff; wr_bg_ff <= cmd_out.bg; end
      if (v && cmd_out.kind == K_RD) begin t_rd_ff <= cyc_ff; rd_bk_ff <= {cmd_out.bg, cmd_out.bank}; end
      if (mrs) t_mrs_ff <= cyc_ff;
      if (act) begin
        for (int i = 3; i > 0; i--) t_act_ff[i] <= t_act_ff[i-1];
        t_act_ff[0] <= cyc_ff;
      end
    end
  end
  chk_col_same_grp: assert property (col && cmd_out.bg == col_bg_ff |-> cyc_ff - t_col_ff >= 5)
    else $error("same group column gap short");
  chk_col_any_grp: assert property (col |-> cyc_ff - t_col_ff >= 4)
    else $error("column gap short");
  chk_act_gap: assert property (act |-> cyc_ff - t_act_ff[0] >= 4)
    else $error("activate gap short");
  chk_four_act_win: assert property (act |-> cyc_ff - t_act_ff[3] >= 28)
    else $error("fifth activate inside window");
  chk_wr_to_rd: assert property (v && cmd_out.kind == K_RD |->
    cyc_ff - t_wr_ff >= (cmd_out.bg == wr_bg_ff ? 4 : 2) + (crcdm ? 5 : 0)) else $error("write to read short");
  chk_rd_to_pre: assert property (v && cmd_out.kind == K_PRE && {cmd_out.bg, cmd_out.bank} == rd_bk_ff
    |-> cyc_ff - t_rd_ff >= 4) else $error("read to precharge short");
  chk_mode_set_gap: assert property (mrs |-> cyc_ff - t_mrs_ff >= (ctrl_ff.cal_en ? 27 : 8))
    else $error("mode set gap short");
  chk_mode_update: assert property (v && !mrs |-> cyc_ff - t_mrs_ff >= (ctrl_ff.cal_en ? 27 : 24))
    else $error("command inside mode update");
  chk_cs_lead: assert property (v && ctrl_ff.cal_en |-> !cs_n_out && $past(cs_n_out, 1) == 1'b0 &&
    $past(cs_n_out, 2) == 1'b0 && $past(cs_n_out, 3) == 1'b0) else $error("chip select lead short");
  chk_pda_low: assert property (mrs && ctrl_ff.per_device_addressing |-> dq0_oe_out && !dq0_out)
    else $error("data bit 0 not held low");
  cov_same_grp: cover property (col && cmd_out.bg == col_bg_ff);
  cov_fifth_act: cover property (act && t_act_ff[3] != 0);
  cov_cal_mrs: cover property (mrs && ctrl_ff.cal_en);
endmodule : ddrsp_properties

bind ddrsp_ctrl ddrsp_properties u_props (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
  .cs_n_out(cs_n_out), .dq0_out(dq0_out), .dq0_oe_out(dq0_oe_out));

// [dv/ddrsp_dev_model.sv]
// Purpose: device side of the command pins
// Assumes: dq0 line is terminated high when released
// Notes: counts every command pulse, and chip select faults
`timescale 1ns/1ps
module ddrsp_dev_model
  import ddrsp_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          reset_in,
  input  wire ddrsp_cmd_type cmd_in,
  input  wire logic          cmd_valid_in,
  input  wire logic          cs_n_in,
  input  wire logic          dq0_drv_in,
  input  wire logic          dq0_oe_in,
  output logic               dq0_line_out,
  output logic [15:0]        cmd_count_out,
  output logic [15:0]        fault_count_out
);
  // line level from the only driver, else termination
  assign dq0_line_out = dq0_oe_in ? dq0_drv_in : 1'b1;
  // count every command pulse, and a fault when chip select is high
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cmd_count_out <= '0;
      fault_count_out <= '0;
    end else if (cmd_valid_in) begin
      cmd_count_out <= cmd_count_out + 16'h0001;
      if (cs_n_in) fault_count_out <= fault_count_out + 16'h0001;
    end
  end
endmodule : ddrsp_dev_model

// [dv/ddrsp_ctrl_tb.sv]
// Purpose: drives the spacing controller through its register port
// Assumes: 50 ns clock; ns minimums fold to one cycle
// Notes: gaps are cycles between command pulses, lower bounds
`timescale 1ns/1ps
module ddrsp_ctrl_tb
  import ddrsp_pkg::*;
;
  logic          clock_in, reset_in, wr_in, rd_in;  // clock, reset, strobes
  logic [7:0]    addr_in;        // register address
  logic [31:0]   wdata_in;       // write data
  logic [31:0]   rdata_out;      // read data
  ddrsp_cmd_type cmd_out;        // command pins
  logic          cmd_valid_out;  // command cycle
  logic          cs_n_out;       // chip select
  logic          dq0_in, dq0_out, dq0_oe_out;  // dq0 line, drive, enable
  logic [15:0]   dev_cmds, dev_faults;  // device side counts
  int            err_count = 0;  // mismatches
  int            tests_run = 0;  // comparisons
  int            cyc = 0;        // cycle stamp
  int            low_seen = 0;   // cycles with dq0 low
  ddrsp_ctrl uut (.clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
    .cs_n_out(cs_n_out), .dq0_in(dq0_in), .dq0_out(dq0_out), .dq0_oe_out(dq0_oe_out));
  ddrsp_dev_model dev (.clock_in(clock_in), .reset_in(reset_in), .cmd_in(cmd_out), .cmd_valid_in(cmd_valid_out),
    .cs_n_in(cs_n_out), .dq0_drv_in(dq0_out), .dq0_oe_in(dq0_oe_out), .dq0_line_out(dq0_in),
    .cmd_count_out(dev_cmds), .fault_count_out(dev_faults));
  // clock and stamps
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (dq0_in === 1'b0) low_seen <= low_seen + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic gap(input int a, input int b, input int n, input string msg);
    check(32'(b - a >= n), 32'h1, msg);
  endtask : gap
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : bus_rd
  function automatic ddrsp_cmd_type mk(input ddrsp_kind_type k, input logic g, input logic [1:0] b);
    return '{kind: k, bg: g, bank: b, ap: 1'b0};
  endfunction : mk
  // wait for the pulse, then judge the pins
  task automatic wait_cmd(input ddrsp_cmd_type c, output int t);
    int n;
    n = 0;
    do begin @(posedge clock_in); #1; n++; end while (cmd_valid_out !== 1'b1 && n < 200);
    check(32'(cmd_out), 32'(c), "command fields");
    check(32'(cs_n_out), 32'h0, "chip select in command");
    t = cyc;
  endtask : wait_cmd
  task automatic issue(input ddrsp_cmd_type c, output int t);
    bus_wr(REG_CMD, {25'h0, c});
    wait_cmd(c, t);
  endtask : issue
  task automatic t_reset;
    logic [31:0] d;
    bus_rd(8'hfc, d);
    check(d, 32'h0, "unmapped read");
    bus_rd(REG_STAT, d);
    check(d, 32'h0008_0000, "status after reset");
    $display("done reset");
  endtask : t_reset
  task automatic t_column;
    int t[6];
    issue(mk(K_WR, 0, 0), t[0]);
    issue(mk(K_WR, 0, 1), t[1]);
    gap(t[0], t[1], 5, "same group column");
    issue(mk(K_RD, 1, 0), t[2]);
    gap(t[1], t[2], 4, "other group column");
    issue(mk(K_WR, 1, 2), t[3]);
    issue(mk(K_RD, 1, 2), t[4]);
    gap(t[3], t[4], 4, "same group write to read");
    issue(mk(K_PRE, 1, 2), t[5]);
    gap(t[4], t[5], 4, "read to precharge");
    $display("done column");
  endtask : t_column
  task automatic t_act;
    int t[5];
    for (int i = 0; i < 5; i++) begin
      issue(mk(K_ACT, i[0], 2'(i / 2)), t[i]);
      if (i > 0) gap(t[i-1], t[i], 4, "activate gap");
    end
    gap(t[0], t[4], 28, "four activate window");
    $display("done activate");
  endtask : t_act
  task automatic t_crcdm;
    int t[5];
    bus_wr(REG_CTRL, 32'h0000_2003);
    issue(mk(K_WR, 0, 3), t[0]);
    issue(mk(K_RD, 0, 3), t[1]);
    gap(t[0], t[1], 9, "same group write to read, crc+mask");
    issue(mk(K_WR, 1, 3), t[2]);
    issue(mk(K_RD, 0, 1), t[3]);
    gap(t[2], t[3], 7, "other group write to read, crc+mask");
    issue(mk(K_PRE, 1, 3), t[4]);
    gap(t[2], t[4], 6, "write recovery, crc+mask");
    $display("done crc and mask");
  endtask : t_crcdm
  task automatic t_mode;
    int t[6];
    logic [31:0] d0, d1;
    bus_rd(REG_STAT, d0);
    issue(mk(K_MRS, 0, 0), t[0]);
    bus_wr(REG_CMD, {25'h0, mk(K_MRS, 0, 1)});
    bus_wr(REG_CMD, {25'h0, mk(K_ACT, 0, 1)});
    wait_cmd(mk(K_MRS, 0, 1), t[1]);
    gap(t[0], t[1], 8, "mode set gap");
    issue(mk(K_MPR_WR, 0, 0), t[2]);
    gap(t[1], t[2], 24, "mode update delay");
    issue(mk(K_ACT, 0, 0), t[5]);
    gap(t[2], t[5], 24, "mpr write gap");
    bus_rd(REG_STAT, d1);
    check(d1[15:0], d0[15:0] + 16'h4, "write while pending refused");
    bus_wr(REG_CTRL, 32'h0000_2004);
    issue(mk(K_MRS, 0, 2), t[3]);
    issue(mk(K_MRS, 0, 3), t[4]);
    gap(t[3], t[4], 27, "mode set gap, latency mode");
    $display("done mode");
  endtask : t_mode
  task automatic t_pda;
    int t, l0;
    l0 = low_seen;
    bus_wr(REG_CTRL, 32'h0000_2008);
    issue(mk(K_MRS, 1, 0), t);
    check(32'(low_seen > l0), 32'h1, "data bit 0 held low");
    repeat (30) @(posedge clock_in);
    #1 check(32'(dq0_in), 32'h1, "data bit 0 released");
    bus_wr(REG_CTRL, 32'h0000_2000);
    $display("done per device");
  endtask : t_pda
  task automatic stop_test;
    $display("counts: %0d compared, %0d mismatched", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // watchdog, far beyond the expected run
  initial begin
    #250000;
    err_count++;
    stop_test();
  end
  initial begin
    clock_in = 1'b0;
    reset_in = 1'b1;
    {wr_in, rd_in, addr_in, wdata_in} = '0;
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    t_reset();
    t_column();
    t_act();
    t_crcdm();
    t_mode();
    t_pda();
    check(32'(dev_faults), 32'h0, "device saw chip select high");
    check(32'(dev_cmds), 32'h17, "device commands");
    stop_test();
  end
endmodule : ddrsp_ctrl_tb
